// ### ccpcap_cfg.svh
// Constants of the capture/compare/PWM control block: offsets, codes, reset values.
// Assumes a 32-bit Avalon-MM slave with byte addresses and one word per register.
`ifndef CCPCAP_CFG_SVH
`define CCPCAP_CFG_SVH

// Register byte offsets.
`define CCPCAP_OFF_CTRL   5'h00
`define CCPCAP_OFF_CAPLO  5'h04
`define CCPCAP_OFF_CAPHI  5'h08
`define CCPCAP_OFF_FLAG   5'h0c
`define CCPCAP_OFF_MASK   5'h10
`define CCPCAP_OFF_TIMER  5'h14

// Mode field codes.
`define CCPCAP_MODE_OFF    4'h0
`define CCPCAP_MODE_FALL   4'h4
`define CCPCAP_MODE_RISE   4'h5
`define CCPCAP_MODE_RISE4  4'h6
`define CCPCAP_MODE_RISE16 4'h7
`define CCPCAP_MODE_CMPSW  4'h2
`define CCPCAP_TOP_CAPTURE 2'h1
`define CCPCAP_TOP_COMPARE 2'h2
`define CCPCAP_TOP_PWM     2'h3

// Prescale terminal counts, clear value and step.
`define CCPCAP_PRE4_LAST  2'h3
`define CCPCAP_PRE16_LAST 4'hf
`define CCPCAP_PRE_ZERO   4'h0
`define CCPCAP_PRE_ONE    4'h1

// Field positions and reset values.
`define CCPCAP_FLAG_BIT   0
`define CCPCAP_CTRL_RST   6'h00
`define CCPCAP_BYTE_RST   8'h00
`define CCPCAP_WORD_ZERO  32'h0000_0000
`define CCPCAP_DUTY_RST   10'h000

`endif

// ### ccpcap_pkg.sv
// Types shared by the capture/compare/PWM control block.
// Assumes ccpcap_cfg.svh supplies the numeric constants.
package ccpcap_pkg;

  // Operating class selected by the mode field.
  typedef enum logic [2:0] {
    ccpcap_off,
    ccpcap_capture,
    ccpcap_compare,
    ccpcap_pwm,
    ccpcap_reserved
  } ccpcap_kind_t;

  // Bus answer sequence.
  typedef enum logic {
    ccpcap_bus_wait,
    ccpcap_bus_ack
  } ccpcap_bus_t;

  // Control register content.
  typedef struct packed {
    logic [1:0] duty_low;
    logic [3:0] mode;
  } ccpcap_ctrl_t;

  // Captured 16-bit value as a byte pair.
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } ccpcap_pair_t;

endpackage

// ### ccpcap_edge_presc.sv
// Capture pin edge detector and capture prescale counter.
// Assumes the capture pin is synchronous to i_clk.
`timescale 1ns/1ps
`include "ccpcap_cfg.svh"

module ccpcap_edge_presc (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_pin,
  input  wire logic [3:0] i_mode,
  output logic            o_event
);

  logic       pin_prev;
  logic       next_pin_prev;
  logic [3:0] count;
  logic [3:0] next_count;
  logic       rise;
  logic       fall;
  logic       is_capture;

  assign rise       = i_pin & ~pin_prev;
  assign fall       = ~i_pin & pin_prev;
  assign is_capture = (i_mode[3:2] == `CCPCAP_TOP_CAPTURE);

  // Count rising edges in any capture mode, cleared otherwise.
  always_comb begin
    next_pin_prev = i_pin;
    next_count    = count;
    if (!is_capture) begin
      next_count = `CCPCAP_PRE_ZERO;
    end else if (rise) begin
      next_count = count + `CCPCAP_PRE_ONE;
    end
  end

  // Select which edge counts as a capture.
  always_comb begin
    unique case (i_mode)
      `CCPCAP_MODE_FALL:   o_event = fall;
      `CCPCAP_MODE_RISE:   o_event = rise;
      `CCPCAP_MODE_RISE4:  o_event = rise && (count[1:0] == `CCPCAP_PRE4_LAST);
      `CCPCAP_MODE_RISE16: o_event = rise && (count == `CCPCAP_PRE16_LAST);
      default:             o_event = 1'b0;
    endcase
  end

  // Register the edge history and the prescale count.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_prev <= 1'b0;
      count    <= `CCPCAP_PRE_ZERO;
    end else begin
      pin_prev <= next_pin_prev;
      count    <= next_count;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  presc_clear_off_a: assert property (!is_capture |=> count == 4'h0)
    else $error("Prescale count not cleared outside capture.");
  presc_keep_switch_a: assert property (is_capture && $past(is_capture) &&
      $changed(i_mode) && !$past(rise) |-> count == $past(count))
    else $error("Prescale count lost on prescale change.");
  fourth_edge_a: assert property (i_mode == 4'h6 && o_event |->
      rise && count[1:0] == 2'h3)
    else $error("Every-fourth capture at wrong edge.");
  falling_edge_a: assert property (i_mode == 4'h4 && $past(i_pin) && !i_pin
      |-> o_event)
    else $error("Falling edge not captured.");
  cover_sixteenth_c: cover property (i_mode == 4'h7 && o_event);

endmodule // ccpcap_edge_presc

// ### ccpcap_top.sv
// Capture/compare/PWM control block with its capture path and register file.
// Assumes an Avalon-MM master, a first timer count and capture pin synchronous to i_clk.
//
// The Avalon-MM interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`include "ccpcap_cfg.svh"

module ccpcap_top (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [4:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic [15:0] i_first_timer_count,
  input  wire logic        i_capture_pin,
  output logic             o_irq,
  output logic             o_use_second_timer,
  output logic             o_capture_active,
  output logic [9:0]       o_pwm_duty
);

  // Register state.
  ccpcap_pkg::ccpcap_ctrl_t capture_compare_control;
  ccpcap_pkg::ccpcap_ctrl_t next_capture_compare_control;
  ccpcap_pkg::ccpcap_pair_t capture_value;
  ccpcap_pkg::ccpcap_pair_t next_capture_value;
  logic                     capture_event_flag;
  logic                     next_capture_event_flag;
  logic                     capture_event_mask;
  logic                     next_capture_event_mask;
  ccpcap_pkg::ccpcap_bus_t  bus_state;
  ccpcap_pkg::ccpcap_bus_t  next_bus_state;
  logic [31:0]              readdata;
  logic [31:0]              next_readdata;
  logic                     use_second_timer;
  logic                     next_use_second_timer;
  logic                     capture_active;
  logic                     next_capture_active;
  logic [9:0]               pwm_duty;
  logic [9:0]               next_pwm_duty;

  // Decoded helpers.
  ccpcap_pkg::ccpcap_kind_t kind;
  logic                     request;
  logic                     do_write;
  logic                     capture_event;
  logic                     flag_clear;

  // Classify the mode field.
  always_comb begin
    unique case (capture_compare_control.mode[3:2])
      2'h0: begin
        if (capture_compare_control.mode == `CCPCAP_MODE_OFF) begin
          kind = ccpcap_pkg::ccpcap_off;
        end else if (capture_compare_control.mode == `CCPCAP_MODE_CMPSW) begin
          kind = ccpcap_pkg::ccpcap_compare;
        end else begin
          kind = ccpcap_pkg::ccpcap_reserved;
        end
      end
      `CCPCAP_TOP_CAPTURE: kind = ccpcap_pkg::ccpcap_capture;
      `CCPCAP_TOP_COMPARE: kind = ccpcap_pkg::ccpcap_compare;
      `CCPCAP_TOP_PWM:     kind = ccpcap_pkg::ccpcap_pwm;
    endcase
  end

  // Edge selection and prescaling of the capture pin.
  ccpcap_edge_presc u_edge (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_pin   (i_capture_pin),
    .i_mode  (capture_compare_control.mode),
    .o_event (capture_event)
  );

  // Bus handshake: one wait cycle, write commits on the acknowledge edge.
  assign request           = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = request && (bus_state == ccpcap_pkg::ccpcap_bus_wait);
  assign do_write          = i_avs_write && (bus_state == ccpcap_pkg::ccpcap_bus_ack);
  assign flag_clear        = do_write && (i_avs_address == `CCPCAP_OFF_FLAG) &&
                             i_avs_byteenable[0] && i_avs_writedata[`CCPCAP_FLAG_BIT];

  // Next bus state and read data.
  always_comb begin
    next_bus_state = ccpcap_pkg::ccpcap_bus_wait;
    next_readdata  = readdata;
    if (request && bus_state == ccpcap_pkg::ccpcap_bus_wait) begin
      next_bus_state = ccpcap_pkg::ccpcap_bus_ack;
      next_readdata  = `CCPCAP_WORD_ZERO;
      unique case (i_avs_address)
        `CCPCAP_OFF_CTRL:  next_readdata[5:0]  = capture_compare_control;
        `CCPCAP_OFF_CAPLO: next_readdata[7:0]  = capture_value.low;
        `CCPCAP_OFF_CAPHI: next_readdata[7:0]  = capture_value.high;
        `CCPCAP_OFF_FLAG:  next_readdata[0]    = capture_event_flag;
        `CCPCAP_OFF_MASK:  next_readdata[0]    = capture_event_mask;
        `CCPCAP_OFF_TIMER: next_readdata[15:0] = i_first_timer_count;
        default:           next_readdata       = `CCPCAP_WORD_ZERO;
      endcase
    end
  end

  // Next control and capture register values.
  always_comb begin
    next_capture_compare_control = capture_compare_control;
    next_capture_value           = capture_value;
    next_capture_event_mask      = capture_event_mask;
    if (do_write && i_avs_byteenable[0]) begin
      unique case (i_avs_address)
        `CCPCAP_OFF_CTRL:  next_capture_compare_control = i_avs_writedata[5:0];
        `CCPCAP_OFF_CAPLO: next_capture_value.low       = i_avs_writedata[7:0];
        `CCPCAP_OFF_CAPHI: next_capture_value.high      = i_avs_writedata[7:0];
        `CCPCAP_OFF_MASK:  next_capture_event_mask      = i_avs_writedata[0];
        default:           next_capture_value           = capture_value;
      endcase
    end
    // A capture overwrites the pair, winning over a software write.
    if (capture_event && kind == ccpcap_pkg::ccpcap_capture) begin
      next_capture_value = i_first_timer_count;
    end
  end

  // Next flag: a capture wins over a same-cycle clear.
  always_comb begin
    next_capture_event_flag = capture_event_flag;
    if (flag_clear) begin
      next_capture_event_flag = 1'b0;
    end
    if (capture_event) begin
      next_capture_event_flag = 1'b1;
    end
  end

  // Next outputs toward the timers and PWM generator.
  always_comb begin
    next_use_second_timer = (kind == ccpcap_pkg::ccpcap_pwm);
    next_capture_active   = (kind == ccpcap_pkg::ccpcap_capture);
    next_pwm_duty         = pwm_duty;
    if (kind == ccpcap_pkg::ccpcap_pwm) begin
      next_pwm_duty = {capture_value.low, capture_compare_control.duty_low};
    end
  end

  // Register all state.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      capture_compare_control <= `CCPCAP_CTRL_RST;
      capture_value           <= {`CCPCAP_BYTE_RST, `CCPCAP_BYTE_RST};
      capture_event_flag      <= 1'b0;
      capture_event_mask      <= 1'b0;
      bus_state               <= ccpcap_pkg::ccpcap_bus_wait;
      readdata                <= `CCPCAP_WORD_ZERO;
      use_second_timer        <= 1'b0;
      capture_active          <= 1'b0;
      pwm_duty                <= `CCPCAP_DUTY_RST;
    end else begin
      capture_compare_control <= next_capture_compare_control;
      capture_value           <= next_capture_value;
      capture_event_flag      <= next_capture_event_flag;
      capture_event_mask      <= next_capture_event_mask;
      bus_state               <= next_bus_state;
      readdata                <= next_readdata;
      use_second_timer        <= next_use_second_timer;
      capture_active          <= next_capture_active;
      pwm_duty                <= next_pwm_duty;
    end
  end

  // Outputs.
  assign o_avs_readdata     = readdata;
  assign o_irq              = capture_event_flag & capture_event_mask;
  assign o_use_second_timer = use_second_timer;
  assign o_capture_active   = capture_active;
  assign o_pwm_duty         = pwm_duty;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  capture_loads_timer_a: assert property (capture_event |=>
      capture_value == $past(i_first_timer_count))
    else $error("Capture did not load the timer count.");
  capture_overwrites_a: assert property (capture_event && capture_event_flag
      |=> capture_value == $past(i_first_timer_count))
    else $error("Capture over an unread value did not overwrite.");
  flag_sets_capture_a: assert property (capture_event |=> capture_event_flag)
    else $error("Capture flag not set.");
  flag_holds_a: assert property (capture_event_flag && !flag_clear
      |=> capture_event_flag)
    else $error("Capture flag cleared without software.");
  second_timer_pwm_a: assert property (kind == ccpcap_pkg::ccpcap_pwm
      |=> o_use_second_timer)
    else $error("PWM not on second timer.");
  pwm_duty_join_a: assert property (kind == ccpcap_pkg::ccpcap_pwm ##1
      kind == ccpcap_pkg::ccpcap_pwm |-> o_pwm_duty[9:2] == $past(capture_value.low))
    else $error("PWM duty not built from low byte.");
  off_no_capture_a: assert property (capture_compare_control.mode == 4'h0
      |-> !capture_event)
    else $error("Capture while off.");
  bus_answer_a: assert property (request && o_avs_waitrequest |=>
      !o_avs_waitrequest || !request)
    else $error("Bus answer later than one cycle.");
  irq_level_a: assert property (o_irq == (capture_event_flag && capture_event_mask))
    else $error("Interrupt output disagrees with flag and mask.");

  cover_capture_c: cover property (capture_event ##1 capture_event_flag);
  cover_clear_c: cover property (flag_clear && capture_event);
  cover_pwm_c: cover property (kind == ccpcap_pkg::ccpcap_pwm);

endmodule // ccpcap_top

// ### ccpcap_event_src.sv
// Far-side model: the synchronous first timer and the external capture signal.
// Assumes the bench steers the level and the timer through the ports below.
`timescale 1ns/1ps

module ccpcap_event_src (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_run,
  input  wire logic        i_load,
  input  wire logic [15:0] i_value,
  input  wire logic        i_level,
  output logic [15:0]      o_count,
  output logic             o_pin
);
  // The timer steps on the system clock edge only, never asynchronously.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_count <= 16'h0000;
    end else if (i_load) begin
      o_count <= i_value;
    end else if (i_run) begin
      o_count <= o_count + 16'h0001;
    end
  end

  // The capture pin is only ever driven from this side, as an input of the block.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pin <= 1'b0;
    end else begin
      o_pin <= i_level;
    end
  end
endmodule // ccpcap_event_src

// ### tb_top.sv
// Self-checking bench of the capture/compare/PWM control block.
// Assumes the register map of ccpcap_cfg.svh and one wait cycle per bus access.
`timescale 1ns/1ps
`include "ccpcap_cfg.svh"

module tb_top;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic        lvl = 1'b0;
  logic        run = 1'b0;
  logic        load = 1'b0;
  logic [4:0]  addr = 5'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [15:0] tval = 16'h0000;
  logic [31:0] rdata;
  logic        wreq;
  logic        irq;
  logic        use2;
  logic        capact;
  logic [9:0]  duty;
  logic [15:0] tcount;
  logic        pin;
  int          err_total = 0;
  int          checks = 0;

  // System clock of 100 MHz.
  always #5 i_clk = ~i_clk;

  ccpcap_top dut (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hf),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_first_timer_count(tcount),
    .i_capture_pin(pin), .o_irq(irq), .o_use_second_timer(use2),
    .o_capture_active(capact), .o_pwm_duty(duty));

  ccpcap_event_src src (.i_clk(i_clk), .i_rst(i_rst), .i_run(run), .i_load(load),
    .i_value(tval), .i_level(lvl), .o_count(tcount), .o_pin(pin));

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One Avalon access, held until waitrequest is seen low at a rising edge.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_clk);
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdata <= d;
    // Waitrequest and read data are sampled at the rising edge, as the master sees them.
    do begin
      @(posedge i_clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (n >= 50) begin
      err_total++;
      $display("CHECK FAILED at %0t: bus answer missing", $time);
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  // Register write and checked register read.
  task automatic wreg(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(q, exp);
  endtask

  // Whole pulses on the capture pin, then time for the capture to land.
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge i_clk);
      lvl <= 1'b1;
      repeat (2) @(posedge i_clk);
      lvl <= 1'b0;
      repeat (2) @(posedge i_clk);
    end
    repeat (3) @(posedge i_clk);
  endtask

  // Loads the frozen timer with a known count.
  task automatic set_timer(input logic [15:0] v);
    @(posedge i_clk);
    load <= 1'b1;
    tval <= v;
    @(posedge i_clk);
    load <= 1'b0;
  endtask

  // Reset values and an unmapped address.
  task automatic t_reset();
    rchk(`CCPCAP_OFF_CTRL, 32'h0000_0000);
    rchk(`CCPCAP_OFF_FLAG, 32'h0000_0000);
    rchk(5'h1c, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    $display("test reset done");
  endtask

  // Rising-edge capture, sticky flag, interrupt, overwrite and masking.
  task automatic t_capture();
    wreg(`CCPCAP_OFF_MASK, 32'h0000_0001);
    set_timer(16'h1234);
    rchk(`CCPCAP_OFF_TIMER, 32'h0000_1234);
    wreg(`CCPCAP_OFF_CTRL, 32'h0000_0005);
    pulses(1);
    rchk(`CCPCAP_OFF_CAPLO, 32'h0000_0034);
    rchk(`CCPCAP_OFF_CAPHI, 32'h0000_0012);
    chk({31'h0, irq}, 32'h0000_0001);
    chk({30'h0, capact, use2}, 32'h0000_0002);
    repeat (50) @(posedge i_clk);
    rchk(`CCPCAP_OFF_FLAG, 32'h0000_0001);
    set_timer(16'habcd);
    pulses(1);
    rchk(`CCPCAP_OFF_CAPHI, 32'h0000_00ab);
    rchk(`CCPCAP_OFF_CAPLO, 32'h0000_00cd);
    wreg(`CCPCAP_OFF_FLAG, 32'h0000_0001);
    rchk(`CCPCAP_OFF_FLAG, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    wreg(`CCPCAP_OFF_MASK, 32'h0000_0000);
    pulses(1);
    rchk(`CCPCAP_OFF_FLAG, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000);
    wreg(`CCPCAP_OFF_FLAG, 32'h0000_0001);
    $display("test capture done");
  endtask

  // Falling-edge mode ignores the rising half of a pulse.
  task automatic t_fall();
    run <= 1'b1;
    wreg(`CCPCAP_OFF_CTRL, 32'h0000_0000);
    wreg(`CCPCAP_OFF_CTRL, 32'h0000_0004);
    @(posedge i_clk);
    lvl <= 1'b1;
    repeat (4) @(posedge i_clk);
    rchk(`CCPCAP_OFF_FLAG, 32'h0000_0000);
    lvl <= 1'b0;
    repeat (4) @(posedge i_clk);
    rchk(`CCPCAP_OFF_FLAG, 32'h0000_0001);
    wreg(`CCPCAP_OFF_FLAG, 32'h0000_0001);
    $display("test fall done");
  endtask

  // Prescaled capture: no flag one edge short, flag on the last edge.
  task automatic t_presc(input logic [31:0] mode, input int n);
    wreg(`CCPCAP_OFF_CTRL, 32'h0000_0000);
    wreg(`CCPCAP_OFF_CTRL, mode);
    pulses(n - 1);
    rchk(`CCPCAP_OFF_FLAG, 32'h0000_0000);
    pulses(1);
    rchk(`CCPCAP_OFF_FLAG, 32'h0000_0001);
    wreg(`CCPCAP_OFF_FLAG, 32'h0000_0001);
    $display("test prescale %0h done", mode);
  endtask

  // Switching prescale without turning off keeps the edge count.
  task automatic t_switch();
    wreg(`CCPCAP_OFF_CTRL, 32'h0000_0000);
    wreg(`CCPCAP_OFF_CTRL, 32'h0000_0006);
    pulses(2);
    wreg(`CCPCAP_OFF_CTRL, 32'h0000_0007);
    pulses(13);
    rchk(`CCPCAP_OFF_FLAG, 32'h0000_0000);
    pulses(1);
    rchk(`CCPCAP_OFF_FLAG, 32'h0000_0001);
    wreg(`CCPCAP_OFF_FLAG, 32'h0000_0001);
    $display("test switch done");
  endtask

  // PWM mode: duty word, second timer selected, no captures.
  task automatic t_pwm();
    wreg(`CCPCAP_OFF_CTRL, 32'h0000_002c);
    wreg(`CCPCAP_OFF_CAPLO, 32'h0000_005a);
    pulses(1);
    chk({22'h0, duty}, {22'h0, 8'h5a, 2'b10});
    chk({30'h0, capact, use2}, 32'h0000_0001);
    rchk(`CCPCAP_OFF_CTRL, 32'h0000_002c);
    rchk(`CCPCAP_OFF_FLAG, 32'h0000_0000);
    $display("test pwm done");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Main sequence after a reset of five cycles.
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset();
    t_capture();
    t_fall();
    t_presc(32'h0000_0005, 1);
    t_presc(32'h0000_0006, 4);
    t_presc(32'h0000_0007, 16);
    t_switch();
    t_pwm();
    finish_test();
  end

  // Watchdog far beyond the expected run time.
  initial begin
    #300000;
    err_total++;
    finish_test();
  end
endmodule // tb_top
